// ### rtl/hlt_defines.svh
`ifndef HLT_DEFINES_SVH
`define HLT_DEFINES_SVH
// register indices, byte address is four times the index
`define HLT_IDX_LIMIT_CTRL 12'h28f
`define HLT_IDX_MAIN_CTRL 12'h290
`define HLT_IDX_PERIOD 12'h291
`define HLT_IDX_PULSE 12'h292
`define HLT_IDX_COUNT 12'h293
`define HLT_ADDR_W 14
`define HLT_LIMIT_CTRL_RST 8'h00
`define HLT_MAIN_CTRL_RST 8'h00
`define HLT_PERIOD_RST 8'hff
`define HLT_PULSE_RST 8'h00
`define HLT_COUNT_RST 8'h00
// limit control fields
`define HLT_F_PRESCALER_SYNC_ENABLE 7
`define HLT_F_INPUT_CLOCK_POLARITY 6
`define HLT_F_ENABLE_SYNC_SELECT 5
`define HLT_F_MODE_HI 4
`define HLT_MODE_LVL_LOW 5'h0e
`define HLT_MODE_LVL_HIGH 5'h0f
// main control fields
`define HLT_F_ON 0
`define HLT_F_PWM_EN 1
`define HLT_F_PRE_HI 4
`define HLT_F_PRE_LO 2
`define HLT_F_CLK_SYS 7
`define HLT_ON_SYNC_DEPTH 2
`endif

// ### rtl/hlt_pkg.sv
package hlt_pkg;
  typedef enum logic [0:0] {
    HLT_ST_IDLE = 1'b0,
    HLT_ST_RUN = 1'b1
  } hlt_state_type;
endpackage

// ### rtl/hlt_timer.sv
// What this block does
// - level mode holds count clear, edge starts
// - mode 01110 low reset, 01111 high
// - period match clears count; in level mode it clears enable too
// - restart needs enable then fresh edge
// - pulse output goes active on start edge
// - pulse output drops at pulse compare match
// - period match never starts new pulse
// - bit 7 synchronises prescaler output
// - sync bit gives valid reads, sleep halt
// - bit 6 selects input clock edge
// - bit 5 synchronises enable to input clock
// - synced enable acts after two steps: input clock edges, plus synced ticks when bit 7 is set
// - five-bit mode field in low bits
// - other modes run on enable, hold count
// - system-clocked sleep freezes counter and pulse
//
// The APB slave port was decided locally.
`include "hlt_defines.svh"
module hlt_timer (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`HLT_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tmr_clk_in,
  input wire logic ext_reset_in,
  input wire logic sleep_in,
  output logic pulse_out,
  output logic [7:0] count_out
);
  logic [7:0] limit_ctrl_ff, nxt_limit_ctrl;
  logic [7:0] main_ctrl_ff, nxt_main_ctrl;
  logic [7:0] period_ff, nxt_period;
  logic [7:0] pulse_cmp_ff, nxt_pulse_cmp;
  logic [7:0] count_ff, nxt_count;
  logic [6:0] pre_cnt_ff, nxt_pre_cnt;
  logic tclk_ff, nxt_tclk;
  logic tick_sync_ff, nxt_tick_sync;
  logic [`HLT_ON_SYNC_DEPTH-1:0] on_sync_ff, nxt_on_sync;
  logic ext_ff, nxt_ext;
  logic pulse_ff, nxt_pulse;
  hlt_pkg::hlt_state_type state_ff, nxt_state;
  logic [11:0] idx;
  logic acc, wr, hit_limit, hit_main, hit_period, hit_pulse, hit_count;
  logic mapped, raw_edge, pre_tick, tick, halted, run_on;
  logic lvl_mode, reset_lvl, at_reset, start_edge, period_hit;
  logic [6:0] pre_top;
  logic [4:0] mode;

  assign idx = paddr[`HLT_ADDR_W-1:2];
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign hit_limit = idx == `HLT_IDX_LIMIT_CTRL;
  assign hit_main = idx == `HLT_IDX_MAIN_CTRL;
  assign hit_period = idx == `HLT_IDX_PERIOD;
  assign hit_pulse = idx == `HLT_IDX_PULSE;
  assign hit_count = idx == `HLT_IDX_COUNT;
  assign mapped = hit_limit | hit_main | hit_period | hit_pulse | hit_count;
  // zero wait states keeps software timing simple
  assign pready = acc;
  assign pslverr = acc & ~mapped;

  always_comb begin
    prdata = 32'h0000_0000;
    if (acc & ~pwrite) begin
      // valid reads
      // count reads come straight from the flop, never mid-update
      case (1'b1)
        hit_limit: prdata[7:0] = limit_ctrl_ff;
        hit_main: prdata[7:0] = main_ctrl_ff;
        hit_period: prdata[7:0] = period_ff;
        hit_pulse: prdata[7:0] = pulse_cmp_ff;
        hit_count: prdata[7:0] = count_ff;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  assign mode = limit_ctrl_ff[`HLT_F_MODE_HI:0];
  assign lvl_mode = (mode == `HLT_MODE_LVL_LOW) |
                    (mode == `HLT_MODE_LVL_HIGH);
  assign reset_lvl = mode[0];
  assign at_reset = lvl_mode & (ext_reset_in == reset_lvl);

  // sleep freeze
  // an external asynchronous clock would keep counting in sleep unless bit 7 is set
  assign halted = sleep_in & (limit_ctrl_ff[`HLT_F_PRESCALER_SYNC_ENABLE] |
                              main_ctrl_ff[`HLT_F_CLK_SYS]);

  assign raw_edge = main_ctrl_ff[`HLT_F_CLK_SYS] ? 1'b1 :
                    (limit_ctrl_ff[`HLT_F_INPUT_CLOCK_POLARITY] ? (tclk_ff & ~tmr_clk_in) :
                                                  (~tclk_ff & tmr_clk_in));
  assign pre_top = 7'((8'h01 << main_ctrl_ff[`HLT_F_PRE_HI:`HLT_F_PRE_LO])
                      - 8'h01);
  assign pre_tick = raw_edge & (pre_cnt_ff == pre_top) & ~halted;
  // prescaler sync
  // synced path costs one cycle of latency but aligns to clk
  assign tick = limit_ctrl_ff[`HLT_F_PRESCALER_SYNC_ENABLE] ? (tick_sync_ff & ~halted) :
                                              pre_tick;

  assign run_on = limit_ctrl_ff[`HLT_F_ENABLE_SYNC_SELECT] ?
                  (on_sync_ff[`HLT_ON_SYNC_DEPTH-1] &
                   main_ctrl_ff[`HLT_F_ON]) :
                  main_ctrl_ff[`HLT_F_ON];

  assign start_edge = lvl_mode & (ext_ff == reset_lvl) &
                      (ext_reset_in != reset_lvl) & run_on & ~halted;
  assign period_hit = tick & (state_ff == hlt_pkg::HLT_ST_RUN) &
                      (count_ff == period_ff);

  always_comb begin
    nxt_tclk = tmr_clk_in;
    nxt_ext = halted ? ext_ff : ext_reset_in;
    nxt_tick_sync = pre_tick;
    nxt_pre_cnt = pre_cnt_ff;
    if (raw_edge & ~halted) begin
      nxt_pre_cnt = (pre_cnt_ff == pre_top) ? 7'h00 : pre_cnt_ff + 7'h01;
    end
    nxt_on_sync = on_sync_ff;
    if (~main_ctrl_ff[`HLT_F_ON]) begin
      nxt_on_sync = '0;
    end else if (tick | raw_edge & ~halted) begin
      nxt_on_sync = {on_sync_ff[`HLT_ON_SYNC_DEPTH-2:0], 1'b1};
    end
  end

  always_comb begin
    nxt_limit_ctrl = limit_ctrl_ff;
    nxt_main_ctrl = main_ctrl_ff;
    nxt_period = period_ff;
    nxt_pulse_cmp = pulse_cmp_ff;
    nxt_count = count_ff;
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    if (lvl_mode) begin
      if (at_reset & ~halted) begin
        // hold clear
        // held clear with the enable off too, so a start is from zero
        nxt_count = 8'h00;
        nxt_state = hlt_pkg::HLT_ST_IDLE;
      end else if (~run_on) begin
        nxt_state = hlt_pkg::HLT_ST_IDLE;
      end else if (start_edge) begin
        nxt_state = hlt_pkg::HLT_ST_RUN;
        if (main_ctrl_ff[`HLT_F_PWM_EN]) begin
          nxt_pulse = 1'b1;
        end
      end else if (period_hit) begin
        nxt_count = 8'h00;
        nxt_main_ctrl[`HLT_F_ON] = 1'b0;
        nxt_state = hlt_pkg::HLT_ST_IDLE;
        nxt_pulse = 1'b0;
      end else if (tick & (state_ff == hlt_pkg::HLT_ST_RUN)) begin
        nxt_count = count_ff + 8'h01;
      end
    end else begin
      nxt_state = run_on ? hlt_pkg::HLT_ST_RUN : hlt_pkg::HLT_ST_IDLE;
      if (run_on & tick) begin
        nxt_count = (count_ff == period_ff) ? 8'h00 : count_ff + 8'h01;
      end
    end
    if (tick & pulse_ff & (count_ff == pulse_cmp_ff)) begin
      nxt_pulse = 1'b0;
    end
    if (~main_ctrl_ff[`HLT_F_PWM_EN]) begin
      nxt_pulse = 1'b0;
    end
    // software write lands last, so a set of the enable survives a match
    if (wr) begin
      case (1'b1)
        hit_limit: nxt_limit_ctrl = pwdata[7:0];
        hit_main: nxt_main_ctrl = pwdata[7:0];
        hit_period: nxt_period = pwdata[7:0];
        hit_pulse: nxt_pulse_cmp = pwdata[7:0];
        hit_count: nxt_count = pwdata[7:0];
        default: nxt_period = period_ff;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      limit_ctrl_ff <= `HLT_LIMIT_CTRL_RST;
      main_ctrl_ff <= `HLT_MAIN_CTRL_RST;
      period_ff <= `HLT_PERIOD_RST;
      pulse_cmp_ff <= `HLT_PULSE_RST;
      count_ff <= `HLT_COUNT_RST;
      state_ff <= hlt_pkg::HLT_ST_IDLE;
      pulse_ff <= 1'b0;
      pre_cnt_ff <= 7'h00;
      tclk_ff <= 1'b0;
      tick_sync_ff <= 1'b0;
      on_sync_ff <= '0;
      ext_ff <= 1'b0;
    end else begin
      limit_ctrl_ff <= nxt_limit_ctrl;
      main_ctrl_ff <= nxt_main_ctrl;
      period_ff <= nxt_period;
      pulse_cmp_ff <= nxt_pulse_cmp;
      count_ff <= nxt_count;
      state_ff <= nxt_state;
      pulse_ff <= nxt_pulse;
      pre_cnt_ff <= nxt_pre_cnt;
      tclk_ff <= nxt_tclk;
      tick_sync_ff <= nxt_tick_sync;
      on_sync_ff <= nxt_on_sync;
      ext_ff <= nxt_ext;
    end
  end

  assign pulse_out = pulse_ff;
  assign count_out = count_ff;

  property p_hold_clear;
    @(posedge clk) disable iff (!rst_b)
      (at_reset & ~halted & ~(wr & hit_count)) |=> (count_ff == 8'h00);
  endproperty
  a_hold_clear: assert property (p_hold_clear)
    else $error("count not held clear at reset level");

  property p_low_level;
    @(posedge clk) disable iff (!rst_b)
      (mode == `HLT_MODE_LVL_LOW) |-> (at_reset == ~ext_reset_in);
  endproperty
  a_low_level: assert property (p_low_level)
    else $error("low reset level not decoded");

  property p_match_clear;
    @(posedge clk) disable iff (!rst_b)
      (lvl_mode & period_hit & run_on & ~at_reset & ~start_edge & ~wr)
      |=> (count_ff == 8'h00) && !main_ctrl_ff[`HLT_F_ON];
  endproperty
  a_match_clear: assert property (p_match_clear)
    else $error("period match did not clear count and enable");

  property p_no_restart;
    @(posedge clk) disable iff (!rst_b)
      (lvl_mode & state_ff == hlt_pkg::HLT_ST_IDLE & ~start_edge)
      |=> (state_ff == hlt_pkg::HLT_ST_IDLE);
  endproperty
  a_no_restart: assert property (p_no_restart)
    else $error("timer ran without a fresh edge");

  property p_pulse_start;
    @(posedge clk) disable iff (!rst_b)
      (start_edge & ~at_reset & main_ctrl_ff[`HLT_F_PWM_EN] &
       ~(tick & count_ff == pulse_cmp_ff)) |=> pulse_out;
  endproperty
  a_pulse_start: assert property (p_pulse_start)
    else $error("pulse not raised on start edge");

  property p_pulse_end;
    @(posedge clk) disable iff (!rst_b)
      (tick & pulse_ff & count_ff == pulse_cmp_ff) |=> !pulse_out;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse not dropped at compare match");

  property p_match_no_pulse;
    @(posedge clk) disable iff (!rst_b)
      (lvl_mode & period_hit & ~pulse_ff) |=> !pulse_out;
  endproperty
  a_match_no_pulse: assert property (p_match_no_pulse)
    else $error("pulse started at period match");

  property p_sleep_freeze;
    @(posedge clk) disable iff (!rst_b)
      (halted & ~wr) |=> $stable(count_ff) && $stable(pulse_out);
  endproperty
  a_sleep_freeze: assert property (p_sleep_freeze)
    else $error("count or pulse moved during sleep");

  property p_enable_sync_select_delay;
    @(posedge clk) disable iff (!rst_b)
      (limit_ctrl_ff[`HLT_F_ENABLE_SYNC_SELECT] & $rose(main_ctrl_ff[`HLT_F_ON]))
      |-> !run_on;
  endproperty
  a_enable_sync_select_delay: assert property (p_enable_sync_select_delay)
    else $error("synced enable acted at once");

  property p_count_step;
    @(posedge clk) disable iff (!rst_b)
      (~lvl_mode & run_on & tick & ~wr & (count_ff != period_ff))
      |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("count did not step on a tick");

  property p_off_hold;
    @(posedge clk) disable iff (!rst_b)
      (~lvl_mode & ~main_ctrl_ff[`HLT_F_ON] & ~wr) |=> $stable(count_ff);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("count moved while the timer was off");
endmodule // hlt_timer

// ### verif/hlt_ext_src.sv
module hlt_ext_src (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic lvl_cmd,
  input wire logic clk_run,
  output logic ext_reset_in,
  output logic tmr_clk_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_ff;
  // input clock stands still between bursts, like a gated source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_reset_in <= 1'b0;
      tmr_clk_in <= 1'b0;
      div_ff <= 2'h0;
    end else begin
      ext_reset_in <= lvl_cmd;
      if (clk_run) begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3) begin
          tmr_clk_in <= ~tmr_clk_in;
        end
      end
    end
  end
endmodule // hlt_ext_src

// ### verif/tb_hlt_timer.sv
module tb_hlt_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, serr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdat, a;
  logic tmr_clk_in, ext_reset_in, sleep_in, pulse_out, lvl, crun;
  logic [7:0] count_out;
  logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
  int num_errors = 0;
  int compares = 0;
  hlt_timer hlt_timer_i (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tmr_clk_in(tmr_clk_in), .ext_reset_in(ext_reset_in),
    .sleep_in(sleep_in), .pulse_out(pulse_out), .count_out(count_out));
  hlt_ext_src hlt_ext_src_i (.clk(clk), .rst_b(rst_b), .lvl_cmd(lvl),
    .clk_run(crun), .ext_reset_in(ext_reset_in), .tmr_clk_in(tmr_clk_in));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // hold the request until pready is seen high at a rising edge
  task apb(input logic w, input logic [13:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      report_and_stop;
    end
  endtask
  task wait_pulse(input logic v);
    int n;
    n = 0;
    while (pulse_out !== v && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("pulse_out", v, pulse_out);
    if (pulse_out !== v) report_and_stop;
  endtask
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    lvl = 0; crun = 0; sleep_in = 0; rst_b = 0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(0, 14'h0a3c + 14'(4 * i), '0);
      chk("reset value", 32'(rst_tab[i]), rdat);
      chk("slave error", 0, serr);
    end
    apb(0, 14'h0a50, '0);
    chk("unmapped error", 1, serr);
    apb(1, 14'h0a3c, 32'h0000_00a5);
    apb(0, 14'h0a3c, '0);
    chk("limit ctrl", 32'h0000_00a5, rdat);
    apb(1, 14'h0a44, 32'h0000_0004);
    apb(1, 14'h0a48, 32'h0000_0002);
    for (int m = 0; m < 2; m++) begin
      lvl <= m[0];
      apb(1, 14'h0a3c, 32'h0000_000e + m);
      apb(1, 14'h0a40, 32'h0000_0083);
      repeat (10) @(posedge clk);
      apb(0, 14'h0a4c, '0);
      chk("held count", 0, rdat);
      lvl <= ~m[0];
      wait_pulse(1'b1);
      wait_pulse(1'b0);
      repeat (12) @(posedge clk);
      apb(0, 14'h0a40, '0);
      chk("main ctrl", 32'h0000_0082, rdat);
      chk("pulse_out", 0, pulse_out);
      apb(0, 14'h0a4c, '0);
      chk("count at match", 0, rdat);
      chk("count_out", 0, count_out);
      lvl <= m[0];
      repeat (3) @(posedge clk);
      lvl <= ~m[0];
      repeat (10) @(posedge clk);
      apb(0, 14'h0a4c, '0);
      chk("count", 0, rdat);
      chk("pulse_out", 0, pulse_out);
      apb(1, 14'h0a40, 32'h0000_0083);
      repeat (10) @(posedge clk);
      apb(0, 14'h0a4c, '0);
      chk("count after enable", 0, rdat);
      chk("pulse after enable", 0, pulse_out);
    end
    apb(1, 14'h0a3c, 32'h0000_0000);
    apb(1, 14'h0a44, 32'h0000_00ff);
    apb(1, 14'h0a40, 32'h0000_0081);
    sleep_in <= 1'b1;
    apb(0, 14'h0a4c, '0);
    a = rdat;
    repeat (10) @(posedge clk);
    apb(0, 14'h0a4c, '0);
    chk("sleep count", a, rdat);
    sleep_in <= 1'b0;
    repeat (5) @(posedge clk);
    apb(0, 14'h0a4c, '0);
    chk("count resumes", 1, 32'(rdat !== a));
    apb(1, 14'h0a40, 32'h0000_0080);
    apb(0, 14'h0a4c, '0);
    a = rdat;
    repeat (10) @(posedge clk);
    apb(0, 14'h0a4c, '0);
    chk("halted count", a, rdat);
    apb(1, 14'h0a4c, 32'h0000_0000);
    // polarity only changed while the enable is off
    apb(1, 14'h0a3c, 32'h0000_0040);
    apb(1, 14'h0a40, 32'h0000_0001);
    crun <= 1'b1;
    // nine toggles: four falling against five rising edges
    repeat (36) @(posedge clk);
    crun <= 1'b0;
    apb(0, 14'h0a4c, '0);
    chk("input clock count", 4, rdat);
    apb(1, 14'h0a40, 32'h0000_0000);
    apb(1, 14'h0a4c, 32'h0000_0000);
    apb(1, 14'h0a3c, 32'h0000_0060);
    apb(1, 14'h0a40, 32'h0000_0001);
    crun <= 1'b1;
    repeat (36) @(posedge clk);
    crun <= 1'b0;
    apb(0, 14'h0a4c, '0);
    // five falling edges, the first two only arm the enable
    chk("synced enable count", 3, rdat);
    apb(1, 14'h0a40, 32'h0000_0000);
    apb(1, 14'h0a4c, 32'h0000_0000);
    apb(1, 14'h0a3c, 32'h0000_0080);
    apb(1, 14'h0a40, 32'h0000_0089);
    repeat (14) @(posedge clk);
    apb(0, 14'h0a4c, '0);
    // divide by four, plus one clock through the sync stage
    chk("prescaled count", 3, rdat);
    report_and_stop;
  end
endmodule // tb_hlt_timer
